// file: rtl/acsd_pkg.sv
package acsd_pkg;

    // Command word and output word sizes
    localparam int unsigned CMD_BITS = 8;
    localparam int unsigned CTRL_BITS = 3;
    localparam int unsigned ADDR_BITS = 5;
    localparam int unsigned WORD_BITS = 32;
    localparam int unsigned CHAN_BITS = 4;

    // Control bit patterns at the head of the command word
    localparam logic [2:0] CTRL_UPDATE = 3'h5;
    localparam logic [2:0] CTRL_KEEP = 3'h4;
    localparam logic [2:0] CTRL_IDLE = 3'h0;

    // Channel address fields
    localparam logic [4:0] DEFAULT_ADDR = 5'h00;
    localparam int unsigned ADDR_SGL_POS = 4;
    localparam int unsigned ADDR_ODD_POS = 3;
    localparam int unsigned ADDR_PAIR_MSB_POS = 2;

    // Register offsets (byte addresses)
    localparam logic [11:0] REG_RESULT = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SELECT = 12'h008;
    localparam logic [11:0] REG_LASTCMD = 12'h00C;

    // RESULT fields
    localparam int unsigned RES_CODE_W = 22;
    localparam int unsigned RES_SIGN_POS = 22;
    localparam int unsigned RES_OVER_POS = 23;
    localparam int unsigned RES_UNDER_POS = 24;
    localparam int unsigned RES_USED_W = 25;
    localparam logic [24:0] RESULT_RESET = 25'h000000;

    // STATUS fields
    localparam int unsigned ST_EOC_N_POS = 0;
    localparam int unsigned ST_FRAME_POS = 1;
    localparam int unsigned ST_UPD_PEND_POS = 2;
    localparam int unsigned ST_PEND_ADDR_LSB = 3;

    // SELECT fields
    localparam int unsigned SEL_ADDR_LSB = 0;
    localparam int unsigned SEL_POS_LSB = 8;
    localparam int unsigned SEL_NEG_LSB = 12;
    localparam int unsigned SEL_COM_POS = 16;

    // LASTCMD fields
    localparam int unsigned LC_CMD_LSB = 0;
    localparam int unsigned LC_VALID_POS = 8;

    // Serial output word fields
    localparam int unsigned W_EOC_POS = 31;
    localparam int unsigned W_DMY_POS = 30;
    localparam int unsigned W_SIG_POS = 29;
    localparam int unsigned W_MSB_POS = 28;
    localparam int unsigned W_DATA_LSB = 6;
    localparam int unsigned W_CH_LSB = 1;
    localparam int unsigned W_PAR_POS = 0;

    // Synchroniser reset values: {cs_n, started, cmd_done}
    localparam logic [2:0] SYNC_RESET = 3'h4;

endpackage

// file: rtl/acsd_sync.sv
`timescale 1ns/10ps
module acsd_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial begin
        if (WIDTH < 1) begin
            $error("acsd_sync: WIDTH must be at least 1");
        end
    end

    // Two-stage level synchroniser
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// file: rtl/acsd_decoder.sv
`timescale 1ns/10ps
// Notes on behaviour
// - After reset the first conversion uses address 00000: CH0 positive, CH1 negative.
// - Each data phase after a conversion may carry one eight-bit selection command.
// - Serial input bits are sampled on rising serial clock edges.
// - First three received bits are control, the remaining five the channel address.
// - Control 101 loads the five following bits as the new channel address, with bit 2 forced to 0 when CHANNELS is 8.
// - Control 100 keeps the previous selection and ignores the address bits.
// - Control 000 also keeps the previous selection, so SDI may be tied low.
// - Address mode bit: zero differential pair, one single-ended against common pin.
// - Differential mode joins channels 2k and 2k+1; polarity bit swaps their signs.
// - Single-ended mode uses channel 2k plus polarity bit against the common pin.
// - The converter measures positive channel minus negative channel of the selection.
// - Results beyond full scale use output codes distinct from in-range codes.
// - Capture starts at the first rising edge; selection applies to the next conversion.
// - Overrange shows sign and MSB both high, underrange both low.
module acsd_decoder #(
    parameter int unsigned CHANNELS = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    output logic [3:0] pos_chan_o,
    output logic [3:0] neg_chan_o,
    output logic neg_common_o,
    output logic conv_start_o
);

    initial begin
        if (CHANNELS != 8 && CHANNELS != 16) begin
            $error("acsd_decoder: CHANNELS must be 8 or 16");
        end
    end

    // Decodes a channel address into {neg_common, neg, pos}
    function automatic logic [8:0] decode_sel(input logic [4:0] addr);
        logic [3:0] even_ch;
        logic [3:0] odd_ch;
        logic [3:0] pos;
        logic [3:0] neg;
        logic common_negative_pin;
        even_ch = {addr[2:0], 1'b0};
        odd_ch = {addr[2:0], 1'b1};
        if (addr[acsd_pkg::ADDR_SGL_POS]) begin
            pos = addr[acsd_pkg::ADDR_ODD_POS] ? odd_ch : even_ch;
            neg = 4'h0;
            common_negative_pin = 1'b1;
        end else if (addr[acsd_pkg::ADDR_ODD_POS]) begin
            pos = odd_ch;
            neg = even_ch;
            common_negative_pin = 1'b0;
        end else begin
            pos = even_ch;
            neg = odd_ch;
            common_negative_pin = 1'b0;
        end
        return {common_negative_pin, neg, pos};
    endfunction

    // Parity over the upper 31 bits of the output word
    function automatic logic word_parity(input logic [31:0] w);
        return ^w[31:1];
    endfunction

    // ---------------- Link domain (serial clock) ----------------

    logic [5:0] rise_cnt_q;
    logic [6:0] cmd_shift_q;
    logic [7:0] cmd_q;
    logic cmd_done_q;
    logic started_q;
    logic [4:0] fall_cnt_q;
    logic [4:0] out_idx;
    logic [31:0] word_q;

    // Rising edges seen in this frame, saturating at the word length
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_cnt_q <= 6'h00;
        end else if (rise_cnt_q != 6'(acsd_pkg::WORD_BITS)) begin
            rise_cnt_q <= rise_cnt_q + 6'h01;
        end
    end

    // Shift in command bits MSB first from the first rising edge
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cmd_shift_q <= 7'h00;
        end else if (rise_cnt_q < 6'(acsd_pkg::CMD_BITS - 1)) begin
            cmd_shift_q <= {cmd_shift_q[5:0], sdi_i};
        end
    end

    // Whole command captured at the eighth rising edge only
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            cmd_q <= 8'h00;
            cmd_done_q <= 1'b0;
        end else if (rise_cnt_q == 6'(acsd_pkg::CMD_BITS - 1)) begin
            cmd_q <= {cmd_shift_q, sdi_i};
            cmd_done_q <= 1'b1;
        end
    end

    // Marks that the frame went past its first rising edge
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    // Output bit index advances on falling edges
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fall_cnt_q <= 5'h00;
        end else if (fall_cnt_q != 5'h1F) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
        end
    end

    assign out_idx = 5'h1F - fall_cnt_q;
    assign sdo_o = word_q[out_idx];
    assign sdo_oe_n_o = cs_n_i;

    // ---------------- Core domain ----------------

    logic [2:0] sync_vec;
    logic cs_sync;
    logic started_sync;
    logic done_sync;
    logic cs_prev_q;
    logic done_prev_q;
    logic frame_started_q;
    logic cmd_valid_q;
    logic [7:0] cmd_cap_q;
    logic [7:0] last_cmd_q;
    logic last_valid_q;
    logic [4:0] conv_addr_q;
    logic eoc_n_q;
    logic [24:0] result_q;
    logic [31:0] word_d;
    logic [31:0] prdata_q;
    logic conv_start_q;
    logic [8:0] sel_dec;
    logic frame_end;
    logic done_rise;
    logic [2:0] cmd_ctrl;
    logic [4:0] cmd_addr;
    logic apb_setup;
    logic apb_access;
    logic wr_result;
    logic addr_hit;
    logic sig_bit;
    logic msb_bit;
    logic [21:0] data_bits;

    acsd_sync #(
        .WIDTH(3),
        .RESET_VAL(acsd_pkg::SYNC_RESET)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({cs_n_i, started_q, cmd_done_q}),
        .sync_o(sync_vec)
    );

    assign cs_sync = sync_vec[2];
    assign started_sync = sync_vec[1];
    assign done_sync = sync_vec[0];

    assign done_rise = done_sync & ~done_prev_q;
    assign frame_end = cs_sync & ~cs_prev_q & (frame_started_q | started_sync);

    // Command fields, from the core-domain copy captured when done is seen
    assign cmd_ctrl = cmd_cap_q[7:5];
    assign cmd_addr = cmd_cap_q[4:0];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_prev_q <= 1'b1;
            done_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_sync;
            done_prev_q <= done_sync;
        end
    end

    // Frame counts as a transfer once a rising edge was seen
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frame_started_q <= 1'b0;
        end else if (frame_end) begin
            frame_started_q <= 1'b0;
        end else if (started_sync) begin
            frame_started_q <= 1'b1;
        end
    end

    // Capture the received command word
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_cap_q <= 8'h00;
            cmd_valid_q <= 1'b0;
        end else if (done_rise) begin
            cmd_cap_q <= cmd_q;
            cmd_valid_q <= 1'b1;
        end else if (frame_end) begin
            cmd_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            last_cmd_q <= 8'h00;
            last_valid_q <= 1'b0;
        end else if (done_rise) begin
            last_cmd_q <= cmd_q;
            last_valid_q <= 1'b1;
        end
    end

    // Selection for the next conversion, applied when the frame ends
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_addr_q <= acsd_pkg::DEFAULT_ADDR;
        end else if (frame_end && cmd_valid_q && cmd_ctrl == acsd_pkg::CTRL_UPDATE) begin
            conv_addr_q <= cmd_addr;
            if (CHANNELS == 8) begin
                conv_addr_q[acsd_pkg::ADDR_PAIR_MSB_POS] <= 1'b0;
            end
        end
        // Keep, idle and undefined patterns leave the selection alone
    end

    // Analog selection drives the front end
    assign sel_dec = decode_sel(conv_addr_q);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pos_chan_o <= 4'h0;
            neg_chan_o <= 4'h1;
            neg_common_o <= 1'b0;
        end else begin
            pos_chan_o <= sel_dec[3:0];
            neg_chan_o <= sel_dec[7:4];
            neg_common_o <= sel_dec[8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= frame_end;
        end
    end

    assign conv_start_o = conv_start_q;

    // Conversion state: a result write completes, a frame end restarts
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            eoc_n_q <= 1'b1;
        end else if (wr_result) begin
            eoc_n_q <= 1'b0;
        end else if (frame_end) begin
            eoc_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            result_q <= acsd_pkg::RESULT_RESET;
        end else if (wr_result) begin
            result_q <= pwdata_i[acsd_pkg::RES_USED_W-1:0];
        end
    end

    // Status and data bits, with distinct out-of-range codes
    always_comb begin
        if (result_q[acsd_pkg::RES_OVER_POS]) begin
            sig_bit = 1'b1;
            msb_bit = 1'b1;
            data_bits = 22'h00000;
        end else if (result_q[acsd_pkg::RES_UNDER_POS]) begin
            sig_bit = 1'b0;
            msb_bit = 1'b0;
            data_bits = 22'h3FFFFF;
        end else begin
            sig_bit = result_q[acsd_pkg::RES_SIGN_POS];
            msb_bit = ~result_q[acsd_pkg::RES_SIGN_POS];
            data_bits = result_q[acsd_pkg::RES_CODE_W-1:0];
        end
    end

    always_comb begin
        word_d = 32'h00000000;
        word_d[acsd_pkg::W_EOC_POS] = eoc_n_q;
        word_d[acsd_pkg::W_DMY_POS] = 1'b0;
        word_d[acsd_pkg::W_SIG_POS] = sig_bit;
        word_d[acsd_pkg::W_MSB_POS] = msb_bit;
        word_d[acsd_pkg::W_MSB_POS-1:acsd_pkg::W_DATA_LSB] = data_bits;
        word_d[acsd_pkg::W_DATA_LSB-1:acsd_pkg::W_CH_LSB] = conv_addr_q;
        word_d[acsd_pkg::W_PAR_POS] = word_parity(word_d);
    end

    // Output word only changes while no frame is open
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            word_q <= 32'h80000000;
        end else if (cs_sync && cs_prev_q) begin
            word_q <= word_d;
        end
    end

    // ---------------- APB slave ----------------

    assign apb_setup = psel_i & ~penable_i;
    assign apb_access = psel_i & penable_i;
    assign addr_hit = (paddr_i == acsd_pkg::REG_RESULT) || (paddr_i == acsd_pkg::REG_STATUS)
        || (paddr_i == acsd_pkg::REG_SELECT) || (paddr_i == acsd_pkg::REG_LASTCMD);
    assign wr_result = apb_access & pwrite_i & (paddr_i == acsd_pkg::REG_RESULT);

    // Read data is registered in the setup cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_q <= 32'h00000000;
        end else if (apb_setup) begin
            prdata_q <= 32'h00000000;
            unique case (paddr_i)
                acsd_pkg::REG_RESULT: begin
                    prdata_q[acsd_pkg::RES_USED_W-1:0] <= result_q;
                end
                acsd_pkg::REG_STATUS: begin
                    prdata_q[acsd_pkg::ST_EOC_N_POS] <= eoc_n_q;
                    prdata_q[acsd_pkg::ST_FRAME_POS] <= ~cs_sync;
                    prdata_q[acsd_pkg::ST_UPD_PEND_POS] <=
                        cmd_valid_q && (cmd_ctrl == acsd_pkg::CTRL_UPDATE);
                    prdata_q[acsd_pkg::ST_PEND_ADDR_LSB+4:acsd_pkg::ST_PEND_ADDR_LSB] <= cmd_addr;
                end
                acsd_pkg::REG_SELECT: begin
                    prdata_q[acsd_pkg::SEL_ADDR_LSB+4:acsd_pkg::SEL_ADDR_LSB] <= conv_addr_q;
                    prdata_q[acsd_pkg::SEL_POS_LSB+3:acsd_pkg::SEL_POS_LSB] <= pos_chan_o;
                    prdata_q[acsd_pkg::SEL_NEG_LSB+3:acsd_pkg::SEL_NEG_LSB] <= neg_chan_o;
                    prdata_q[acsd_pkg::SEL_COM_POS] <= neg_common_o;
                end
                acsd_pkg::REG_LASTCMD: begin
                    prdata_q[acsd_pkg::LC_CMD_LSB+7:acsd_pkg::LC_CMD_LSB] <= last_cmd_q;
                    prdata_q[acsd_pkg::LC_VALID_POS] <= last_valid_q;
                end
                default: begin
                    prdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = apb_access & (~addr_hit
        | (pwrite_i & (paddr_i != acsd_pkg::REG_RESULT)));

endmodule

// file: sim/acsd_checker.sv
`timescale 1ns/10ps
module acsd_checker #(
    parameter int unsigned CHANNELS = 16
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_n_o,
    input wire logic [3:0] pos_chan_o,
    input wire logic [3:0] neg_chan_o,
    input wire logic neg_common_o,
    input wire logic conv_start_o
);
    logic [3:0] low_cnt_q;
    logic [8:0] sel_w;
    assign sel_w = {pos_chan_o, neg_chan_o, neg_common_o};
    // Cycles that chip select has been low
    always_ff @(posedge clk_i) begin
        if (srst_i || cs_n_i) begin
            low_cnt_q <= 4'h0;
        end else if (low_cnt_q != 4'hF) begin
            low_cnt_q <= low_cnt_q + 4'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sel_reset_a: assert property (disable iff (1'b0) srst_i |=>
        pos_chan_o == 4'h0 && neg_chan_o == 4'h1 && !neg_common_o) else $error("bad reset sel");
    diff_pair_a: assert property (!neg_common_o |->
        neg_chan_o == (pos_chan_o ^ 4'h1)) else $error("pair mismatch");
    sel_change_a: assert property (!$stable(sel_w) |-> $past(conv_start_o))
        else $error("selection moved without conversion start");
    frame_hold_a: assert property (low_cnt_q >= 4'h6 |-> $stable(sel_w))
        else $error("selection moved inside a frame");
    conv_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    conv_late_a: assert property (conv_start_o |-> $past(cs_n_i, 1) && $past(cs_n_i, 2))
        else $error("start pulse before frame end");
    out_enable_a: assert property (sdo_oe_n_o == cs_n_i)
        else $error("output enable does not follow select");
    bus_ready_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("no ready in access phase");
    conv_c: cover property (conv_start_o);
    single_c: cover property ($rose(neg_common_o));
    err_c: cover property (pslverr_o);
endmodule

// file: sim/acsd_host.sv
`timescale 1ns/10ps
module acsd_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // One frame of nbits rising edges at a 32 ns period; clock idles low outside frames
    task automatic frame(input logic [7:0] cmd, input int nbits, input int slow,
        output logic [31:0] word);
        word = 32'h0;
        #3 cs_n_o = 1'b0;
        // Slow host waits longer before the first edge
        #(200 + 40 * slow);
        for (int i = 0; i < nbits; i++) begin
            sdi_o = (i < 8) ? cmd[7 - i] : ~sdi_o;
            #16;
            word = {word[30:0], sdo_i};
            sck_o = 1'b1;
            #16;
            sck_o = 1'b0;
        end
        #200;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #300;
    endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    localparam int N_CH = 16;
    logic clk_i = 1'b0, srst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, res, seed = 32'h00010605;
    logic pready, pslverr, err, sck, cs_n, sdi, sdo, sdo_oe_n, neg_com, conv;
    logic [3:0] pos, neg;
    logic [4:0] sel;
    logic [7:0] cmd;
    logic [2:0] ctl [3] = '{3'h5, 3'h4, 3'h0};
    int n_fail = 0, n_compared = 0, n_conv = 0, exp_conv = 0;
    always #25 clk_i = ~clk_i;
    always @(negedge clk_i) if (conv === 1'b1) n_conv++;
    acsd_decoder #(.CHANNELS(N_CH)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sck_i(sck),
        .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .pos_chan_o(pos),
        .neg_chan_o(neg), .neg_common_o(neg_com), .conv_start_o(conv));
    acsd_host u_host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_sel();
        repeat (10) @(posedge clk_i);
        `CHK(pos, {sel[2:0], sel[3]})
        `CHK(neg_com, sel[4])
        if (!sel[4]) `CHK(neg, {sel[2:0], ~sel[3]})
        apb(1'b0, 12'h008, 32'h0, rd, err);
        `CHK(rd[4:0], sel)
        `CHK(n_conv, exp_conv)
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        sel = 5'h00;
        check_sel();
        for (int i = 0; i < 24; i++) begin
            res = rnd();
            apb(1'b1, 12'h000, {7'h00, res[24:0]}, rd, err);
            cmd = {ctl[i % 3], res[31:27]};
            if (N_CH == 8) cmd[2] = 1'b0;
            repeat (4) @(posedge clk_i);
            u_host.frame(cmd, 32, i % 2, rd);
            exp_conv++;
            `CHK(rd[5:1], sel)
            if (cmd[7:5] == 3'h5) sel = cmd[4:0];
            `CHK(rd[31:30], 2'h0)
            `CHK(rd[29:28], res[23] ? 2'h3 : res[24] ? 2'h0 : {res[22], ~res[22]})
            `CHK(rd[27:6], res[23] ? 22'h0 : res[24] ? 22'h3FFFFF : res[21:0])
            check_sel();
            apb(1'b0, 12'h00C, 32'h0, rd, err);
            `CHK(rd[8:0], {1'b1, cmd})
        end
        $display("test select done");
        u_host.frame(8'hBF, 5, 0, rd);
        exp_conv++;
        check_sel();
        u_host.frame(8'hBF, 0, 0, rd);
        check_sel();
        $display("test abort done");
        apb(1'b0, 12'h010, 32'h0, rd, err);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, 12'h008, 32'h0000001F, rd, err);
        `CHK(err, 1'b1)
        check_sel();
        $display("test bus done");
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        sel = 5'h00;
        check_sel();
        $display("test reset done");
        final_report();
    end
endmodule
bind acsd_decoder acsd_checker #(.CHANNELS(CHANNELS)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
    .pos_chan_o(pos_chan_o), .neg_chan_o(neg_chan_o), .neg_common_o(neg_common_o),
    .conv_start_o(conv_start_o));
